/* File: logic/tseg_top.sv */
/*
  Timer software event generation with counter, four channels and an
  APB register slave. Assumes an APB master on MCLK and synchronous
  active-low reset; all outputs are registered.
*/
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "tseg_map.svh"

// Behaviour
// - Writing one to command bit 6 sets the trigger event flag.
// - Every command bit clears itself, so each write is one pulse.
// - Command bits 1 to 4 force a channel event and set its flag.
// - Forced channel event issues that channel's interrupt or DMA if enabled.
// - In input mode a forced channel event captures the counter value.
// - Capture with channel flag already set also sets over-capture flag.
// - Command bit 0 clears the counter when counting up or center-aligned.
// - When counting down the forced update loads the auto-reload value.
// - Forced update also clears the prescaler counter in the same cycle.
// - Writing zero to a command bit makes no event, flags unchanged.
// - Any update event sets the update flag; only software clears it.
// - Reading an input channel's capture value clears its channel flag.
module tseg_top #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt requests, levels
  output logic UP_IRQ,
  output logic [3:0] CH_IRQ,
  output logic TRG_IRQ,
  // DMA requests, one-cycle pulses
  output logic UP_DMA,
  output logic [3:0] CH_DMA,
  output logic TRG_DMA
);

  localparam int NCH = 4;

  // ****************************************
  // APB handshake
  // ****************************************
  logic acc, wr_fire, rd_fire, rd_look, hit;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next, rd_mux;

  // Access takes one wait cycle; the effect lands on the pready edge
  assign acc = PSEL && PENABLE;
  assign wr_fire = acc && PWRITE && pready_reg;
  assign rd_fire = acc && !PWRITE && pready_reg;
  assign rd_look = acc && !pready_reg;

  // ****************************************
  // Control registers
  // ****************************************
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] inten_reg, inten_next;
  logic [NCH-1:0] chmode_reg, chmode_next;
  logic [CW-1:0] psc_reg, psc_next, arr_reg, arr_next;
  logic [15:0] cmd_reg, cmd_next;
  logic up_flag_reg, up_flag_next, trg_flag_reg, trg_flag_next;
  logic up_irq_next, trg_irq_next, up_dma_next, trg_dma_next;
  logic [NCH-1:0] ch_irq_next, ch_dma_next;
  logic up_irq_reg, trg_irq_reg, up_dma_reg, trg_dma_reg;
  logic [NCH-1:0] ch_irq_reg, ch_dma_reg;
  logic flag_wr, upd_ev, ovf, tick;
  logic [CW-1:0] cnt;
  tseg_pkg::tseg_mode_e mode;
  logic [NCH-1:0] ch_flag, ch_of, ch_ev, cv_rd, cv_wr;
  logic [CW-1:0] cv [NCH];

  // Center-aligned selection overrides the direction bit
  always_comb begin
    if (ctrl_reg[`TSEG_CTL_CTR_HI:`TSEG_CTL_CTR_LO] != 2'h0) begin
      mode = tseg_pkg::TSEG_CENTER;
    end else if (ctrl_reg[`TSEG_CTL_DIR]) begin
      mode = tseg_pkg::TSEG_DOWN;
    end else begin
      mode = tseg_pkg::TSEG_UP;
    end
  end

  assign flag_wr = wr_fire && (PADDR == `TSEG_OFF_FLAG);
  assign upd_ev = cmd_reg[`TSEG_CMD_UPD] || ovf;

  // Register writes and the command pulse
  always_comb begin
    ctrl_next = ctrl_reg;
    inten_next = inten_reg;
    chmode_next = chmode_reg;
    psc_next = psc_reg;
    arr_next = arr_reg;
    cmd_next = 16'h0000;
    if (wr_fire) begin
      case (PADDR)
        `TSEG_OFF_CTRL: ctrl_next = PWDATA[15:0];
        `TSEG_OFF_INTEN: inten_next = PWDATA[15:0];
        `TSEG_OFF_CHMODE: chmode_next = PWDATA[NCH-1:0];
        `TSEG_OFF_PSC: psc_next = PWDATA[CW-1:0];
        `TSEG_OFF_ARR: arr_next = PWDATA[CW-1:0];
        // Reserved bits are masked so a careless write makes no event
        `TSEG_OFF_CMD: cmd_next = PWDATA[15:0] & `TSEG_CMD_MASK;
        default: cmd_next = 16'h0000;
      endcase
    end
  end

  // Event flags; set wins over a software clear in the same cycle
  always_comb begin
    up_flag_next = up_flag_reg;
    trg_flag_next = trg_flag_reg;
    if (flag_wr && !PWDATA[`TSEG_FLG_UP]) begin
      up_flag_next = 1'b0;
    end
    if (flag_wr && !PWDATA[`TSEG_FLG_TRG]) begin
      trg_flag_next = 1'b0;
    end
    if (upd_ev) begin
      up_flag_next = 1'b1;
    end
    if (cmd_reg[`TSEG_CMD_TRG]) begin
      trg_flag_next = 1'b1;
    end
  end

  // Requests: interrupts follow flag and enable, DMA pulses per event
  always_comb begin
    up_irq_next = up_flag_next && inten_reg[`TSEG_EN_UP_IRQ];
    trg_irq_next = trg_flag_next && inten_reg[`TSEG_EN_TRG_IRQ];
    up_dma_next = upd_ev && inten_reg[`TSEG_EN_UP_DMA];
    trg_dma_next = cmd_reg[`TSEG_CMD_TRG] && inten_reg[`TSEG_EN_TRG_DMA];
    for (int i = 0; i < NCH; i++) begin
      ch_irq_next[i] = ch_flag[i] && inten_reg[`TSEG_EN_CH0_IRQ + i];
      ch_dma_next[i] = ch_ev[i] && inten_reg[`TSEG_EN_CH0_DMA + i];
    end
  end

  // Read mux; the command register holds nothing and reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (PADDR)
      `TSEG_OFF_CTRL: rd_mux = {16'h0000, ctrl_reg};
      `TSEG_OFF_INTEN: rd_mux = {16'h0000, inten_reg};
      `TSEG_OFF_CHMODE: rd_mux = {28'h0000000, chmode_reg};
      `TSEG_OFF_FLAG: rd_mux = {19'h00000, ch_of, 2'h0, trg_flag_reg, 1'b0, ch_flag, up_flag_reg};
      `TSEG_OFF_CMD: rd_mux = 32'h0000_0000;
      `TSEG_OFF_CNT: rd_mux = 32'(cnt);
      `TSEG_OFF_PSC: rd_mux = 32'(psc_reg);
      `TSEG_OFF_ARR: rd_mux = 32'(arr_reg);
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (PADDR == 12'(`TSEG_OFF_CV0 + `TSEG_CV_STEP * i)) begin
        rd_mux = 32'(cv[i]);
        hit = 1'b1;
      end
    end
  end

  // Bus answer: ready after one wait cycle, error on unmapped address
  always_comb begin
    pready_next = rd_look;
    pslverr_next = rd_look && !hit;
    prdata_next = (rd_look && !PWRITE) ? rd_mux : 32'h0000_0000;
  end

  // State registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctrl_reg <= `TSEG_RST_REG;
      inten_reg <= `TSEG_RST_REG;
      chmode_reg <= '0;
      psc_reg <= '0;
      arr_reg <= CW'(`TSEG_RST_ARR);
      cmd_reg <= `TSEG_RST_REG;
      up_flag_reg <= 1'b0;
      trg_flag_reg <= 1'b0;
      up_irq_reg <= 1'b0;
      trg_irq_reg <= 1'b0;
      up_dma_reg <= 1'b0;
      trg_dma_reg <= 1'b0;
      ch_irq_reg <= '0;
      ch_dma_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      inten_reg <= inten_next;
      chmode_reg <= chmode_next;
      psc_reg <= psc_next;
      arr_reg <= arr_next;
      cmd_reg <= cmd_next;
      up_flag_reg <= up_flag_next;
      trg_flag_reg <= trg_flag_next;
      up_irq_reg <= up_irq_next;
      trg_irq_reg <= trg_irq_next;
      up_dma_reg <= up_dma_next;
      trg_dma_reg <= trg_dma_next;
      ch_irq_reg <= ch_irq_next;
      ch_dma_reg <= ch_dma_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign UP_IRQ = up_irq_reg;
  assign CH_IRQ = ch_irq_reg;
  assign TRG_IRQ = trg_irq_reg;
  assign UP_DMA = up_dma_reg;
  assign CH_DMA = ch_dma_reg;
  assign TRG_DMA = trg_dma_reg;

  // ****************************************
  // Counter engine and channels
  // ****************************************
  tseg_cnt #(
    .W(CW)
  ) u_cnt (
    .clk(MCLK),
    .rst_n(RST_N),
    .cen(ctrl_reg[`TSEG_CTL_CEN]),
    .mode(mode),
    .force_upd(cmd_reg[`TSEG_CMD_UPD]),
    .cnt_wr(wr_fire && (PADDR == `TSEG_OFF_CNT)),
    .cnt_wdata(PWDATA[CW-1:0]),
    .psc(psc_reg),
    .arr(arr_reg),
    .cnt(cnt),
    .ovf(ovf),
    .tick(tick)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Capture-value access strobes for this channel
      assign cv_rd[g] = rd_fire && (PADDR == 12'(`TSEG_OFF_CV0 + `TSEG_CV_STEP * g));
      assign cv_wr[g] = wr_fire && (PADDR == 12'(`TSEG_OFF_CV0 + `TSEG_CV_STEP * g));

      tseg_chan #(
        .W(CW)
      ) u_chan (
        .clk(MCLK),
        .rst_n(RST_N),
        .sw_ev(cmd_reg[`TSEG_CMD_CH0 + g]),
        .tick(tick),
        .input_mode(chmode_reg[g]),
        .cnt(cnt),
        .flag_clr(flag_wr && !PWDATA[`TSEG_FLG_CH0 + g]),
        .of_clr(flag_wr && !PWDATA[`TSEG_FLG_OF0 + g]),
        .rd_clr(cv_rd[g]),
        .cv_wr(cv_wr[g]),
        .cv_wdata(PWDATA[CW-1:0]),
        .flag(ch_flag[g]),
        .of_flag(ch_of[g]),
        .ev(ch_ev[g]),
        .cv(cv[g])
      );

      rd_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        cv_rd[g] && chmode_reg[g] && !cmd_reg[`TSEG_CMD_CH0 + g] |=> !ch_flag[g])
        else $error("capture read did not clear channel flag");
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  cmd_pulse_a: assert property (wr_fire && PADDR == `TSEG_OFF_CMD && PWDATA[`TSEG_CMD_TRG]
    |=> cmd_reg[`TSEG_CMD_TRG] ##1 !cmd_reg[`TSEG_CMD_TRG])
    else $error("command bit did not clear itself");
  trg_flag_a: assert property (cmd_reg[`TSEG_CMD_TRG] |=> trg_flag_reg)
    else $error("trigger flag not set");
  trg_req_a: assert property (cmd_reg[`TSEG_CMD_TRG]
    |=> TRG_DMA == $past(inten_reg[`TSEG_EN_TRG_DMA])
    && TRG_IRQ == $past(inten_reg[`TSEG_EN_TRG_IRQ]))
    else $error("trigger request does not follow its enable");
  ch_flag_a: assert property (cmd_reg[4:1] != 4'h0
    |=> (ch_flag & $past(cmd_reg[4:1])) == $past(cmd_reg[4:1]))
    else $error("channel flag not set by forced event");
  ch_req_a: assert property (cmd_reg[4:1] != 4'h0 |=> (CH_DMA & $past(cmd_reg[4:1]))
    == ($past(cmd_reg[4:1]) & $past(inten_reg[12:9])))
    else $error("channel DMA request does not follow its enable");
  no_event_a: assert property (wr_fire && PADDR == `TSEG_OFF_CMD && PWDATA[6:0] == 7'h00
    |=> cmd_reg == 16'h0000)
    else $error("zero command produced an event");
  upd_flag_a: assert property (cmd_reg[`TSEG_CMD_UPD] |=> up_flag_reg [*2])
    else $error("update flag not set or not sticky");
  cmd_read_a: assert property (rd_look && !PWRITE && PADDR == `TSEG_OFF_CMD
    |=> PREADY && PRDATA == 32'h0)
    else $error("command register read nonzero");

  cover_trg: cover property (cmd_reg[`TSEG_CMD_TRG] && inten_reg[`TSEG_EN_TRG_IRQ]);
  cover_upd_down: cover property (cmd_reg[`TSEG_CMD_UPD] && mode == tseg_pkg::TSEG_DOWN);
  cover_cap_read: cover property (rd_fire && PADDR == `TSEG_OFF_CV0 && chmode_reg[0]);

endmodule : tseg_top

/* File: logic/tseg_map.svh */
/*
  Register offsets, field positions and reset values of the timer
  software event block. Assumes byte addressing on a 32-bit APB bus.
*/
`ifndef TSEG_MAP_SVH
`define TSEG_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TSEG_OFF_CTRL 12'h000
`define TSEG_OFF_CHMODE 12'h008
`define TSEG_OFF_INTEN 12'h00c
`define TSEG_OFF_FLAG 12'h010
`define TSEG_OFF_CMD 12'h014
`define TSEG_OFF_CNT 12'h024
`define TSEG_OFF_PSC 12'h028
`define TSEG_OFF_ARR 12'h02c
`define TSEG_OFF_CV0 12'h034
`define TSEG_CV_STEP 12'h004

// ****************************************
// Field positions
// ****************************************
`define TSEG_CMD_UPD 0
`define TSEG_CMD_CH0 1
`define TSEG_CMD_TRG 6
`define TSEG_CMD_MASK 16'h005f
`define TSEG_FLG_UP 0
`define TSEG_FLG_CH0 1
`define TSEG_FLG_TRG 6
`define TSEG_FLG_OF0 9
`define TSEG_EN_UP_IRQ 0
`define TSEG_EN_CH0_IRQ 1
`define TSEG_EN_TRG_IRQ 6
`define TSEG_EN_UP_DMA 8
`define TSEG_EN_CH0_DMA 9
`define TSEG_EN_TRG_DMA 14
`define TSEG_CTL_CEN 0
`define TSEG_CTL_DIR 4
`define TSEG_CTL_CTR_LO 5
`define TSEG_CTL_CTR_HI 6

// ****************************************
// Reset values
// ****************************************
`define TSEG_RST_REG 16'h0000
`define TSEG_RST_ARR 16'hffff

`endif

/* File: logic/tseg_pkg.sv */
/*
  Types shared by the timer software event block.
  Assumes nothing of its surroundings.
*/
package tseg_pkg;

  // Counting modes of the counter engine
  typedef enum logic [1:0] {
    TSEG_UP,
    TSEG_DOWN,
    TSEG_CENTER
  } tseg_mode_e;

endpackage : tseg_pkg

/* File: logic/tseg_cnt.sv */
/*
  Counter and prescaler engine of the timer, with forced update.
  Assumes force_upd and cnt_wr are one-cycle pulses on clk.
*/
`timescale 1ns/1ps

module tseg_cnt #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic cen,
  input tseg_pkg::tseg_mode_e mode,
  input wire logic force_upd,
  input wire logic cnt_wr,
  input wire logic [W-1:0] cnt_wdata,
  input wire logic [W-1:0] psc,
  input wire logic [W-1:0] arr,
  // Status
  output logic [W-1:0] cnt,
  output logic ovf,
  output logic tick
);

  logic [W-1:0] cnt_reg, cnt_next;
  logic [W-1:0] psc_cnt_reg, psc_cnt_next;
  logic down_reg, down_next;
  logic ovf_reg, ovf_next;

  // Prescaler wraps after psc+1 enabled cycles
  assign tick = cen && (psc_cnt_reg == psc);
  assign cnt = cnt_reg;
  assign ovf = ovf_reg;

  // Next counter state; a forced update beats counting and writes
  always_comb begin
    cnt_next = cnt_reg;
    psc_cnt_next = psc_cnt_reg;
    down_next = down_reg;
    ovf_next = 1'b0;
    if (force_upd) begin
      psc_cnt_next = '0;
      down_next = (mode == tseg_pkg::TSEG_DOWN);
      if (mode == tseg_pkg::TSEG_DOWN) begin
        cnt_next = arr;
      end else begin
        cnt_next = '0;
      end
    end else if (cnt_wr) begin
      cnt_next = cnt_wdata;
    end else if (cen) begin
      if (tick) begin
        psc_cnt_next = '0;
        case (mode)
          tseg_pkg::TSEG_UP: begin
            if (cnt_reg >= arr) begin
              cnt_next = '0;
              ovf_next = 1'b1;
            end else begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
          tseg_pkg::TSEG_DOWN: begin
            if (cnt_reg == '0) begin
              cnt_next = arr;
              ovf_next = 1'b1;
            end else begin
              cnt_next = cnt_reg - 1'b1;
            end
          end
          default: begin
            // Center mode turns at both ends and flags each turn
            if (!down_reg && cnt_reg >= arr) begin
              down_next = 1'b1;
              cnt_next = cnt_reg - 1'b1;
              ovf_next = 1'b1;
            end else if (down_reg && cnt_reg == '0) begin
              down_next = 1'b0;
              cnt_next = cnt_reg + 1'b1;
              ovf_next = 1'b1;
            end else if (down_reg) begin
              cnt_next = cnt_reg - 1'b1;
            end else begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
        endcase
      end else begin
        psc_cnt_next = psc_cnt_reg + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      psc_cnt_reg <= '0;
      down_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      psc_cnt_reg <= psc_cnt_next;
      down_reg <= down_next;
      ovf_reg <= ovf_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  upd_clear_a: assert property (force_upd && mode != tseg_pkg::TSEG_DOWN
    |=> cnt_reg == '0)
    else $error("forced update did not clear the counter");
  upd_reload_a: assert property (force_upd && mode == tseg_pkg::TSEG_DOWN
    |=> cnt_reg == $past(arr))
    else $error("forced update did not reload the counter");
  psc_clear_a: assert property (force_upd |=> psc_cnt_reg == '0 && ovf_reg == 1'b0)
    else $error("forced update did not clear the prescaler");

endmodule : tseg_cnt

/* File: logic/tseg_chan.sv */
/*
  One capture/compare channel: flag, over-capture flag, value register.
  Assumes sw_ev, rd_clr and the write strobes are one-cycle pulses.
*/
`timescale 1ns/1ps

module tseg_chan #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and mode
  input wire logic sw_ev,
  input wire logic tick,
  input wire logic input_mode,
  input wire logic [W-1:0] cnt,
  // Software access
  input wire logic flag_clr,
  input wire logic of_clr,
  input wire logic rd_clr,
  input wire logic cv_wr,
  input wire logic [W-1:0] cv_wdata,
  // State
  output logic flag,
  output logic of_flag,
  output logic ev,
  output logic [W-1:0] cv
);

  logic flag_reg, flag_next;
  logic of_reg, of_next;
  logic [W-1:0] cv_reg, cv_next;
  logic cmp_hit;

  // Compare match only counts on a counter step in output mode
  assign cmp_hit = !input_mode && tick && (cnt == cv_reg);
  assign ev = sw_ev || cmp_hit;
  assign flag = flag_reg;
  assign of_flag = of_reg;
  assign cv = cv_reg;

  // Flags: an event in the clearing cycle still sets the flag
  always_comb begin
    flag_next = flag_reg;
    of_next = of_reg;
    cv_next = cv_reg;
    if (flag_clr || (rd_clr && input_mode)) begin
      flag_next = 1'b0;
    end
    if (ev) begin
      flag_next = 1'b1;
    end
    if (of_clr) begin
      of_next = 1'b0;
    end
    if (sw_ev && input_mode && flag_reg) begin
      of_next = 1'b1;
    end
    if (sw_ev && input_mode) begin
      cv_next = cnt;
    end else if (cv_wr && !input_mode) begin
      cv_next = cv_wdata;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
      of_reg <= 1'b0;
      cv_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      of_reg <= of_next;
      cv_reg <= cv_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  capture_val_a: assert property (sw_ev && input_mode |=> cv_reg == $past(cnt))
    else $error("forced capture did not store the counter");
  overcap_a: assert property (sw_ev && input_mode && flag_reg |=> of_reg)
    else $error("over-capture flag not set");
  cover_overcap: cover property (sw_ev && input_mode && flag_reg);

endmodule : tseg_chan

/* File: sim/timer_soft_event_gen_test.sv */
/*
  Self-checking bench for the timer software event block.
  Assumes the block is tseg_top with an APB slave on MCLK.
*/
`timescale 1ns/1ps
`include "tseg_map.svh"

module timer_soft_event_gen_test;
  // ****************************************
  // Signals and counters
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, up_irq, trg_irq, up_dma, trg_dma;
  logic [3:0] ch_irq, ch_dma;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int trg_seen = 0;
  int up_seen = 0;
  int ch_seen = 0;

  tseg_top #(.CW(16)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .UP_IRQ(up_irq), .CH_IRQ(ch_irq),
    .TRG_IRQ(trg_irq), .UP_DMA(up_dma), .CH_DMA(ch_dma), .TRG_DMA(trg_dma)
  );

  // Clock, watchdog and DMA pulse tallies
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (trg_dma === 1'b1) trg_seen++;
    if (up_dma === 1'b1) up_seen++;
    ch_seen += $countones(ch_dma);
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h, want %h", $time, msg, seen, exp);
    end
  endtask : chk

  // Request held until the edge that samples PREADY high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, "read data");
  endtask : rd_chk

  // Settle past the edge where event outputs land
  task automatic waitn(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : waitn

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(`TSEG_OFF_CMD, 32'h0);
    rd_chk(`TSEG_OFF_ARR, 32'hffff);
    rd_chk(`TSEG_OFF_FLAG, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask : t_reset

  task automatic t_trigger();
    int s;
    wr(`TSEG_OFF_INTEN, 32'h4040);
    s = trg_seen;
    wr(`TSEG_OFF_CMD, 32'h40);
    waitn(2);
    chk({31'h0, trg_irq}, 32'h1, "trigger irq");
    waitn(4);
    chk(trg_seen - s, 32'h1, "trigger dma pulses");
    rd_chk(`TSEG_OFF_FLAG, 32'h40);
    rd_chk(`TSEG_OFF_CMD, 32'h0);
    // Disabled requests must stay quiet
    wr(`TSEG_OFF_FLAG, 32'h0);
    wr(`TSEG_OFF_INTEN, 32'h0);
    s = trg_seen;
    wr(`TSEG_OFF_CMD, 32'h40);
    waitn(2);
    chk({31'h0, trg_irq}, 32'h0, "masked irq");
    chk(trg_seen - s, 32'h0, "masked dma");
    wr(`TSEG_OFF_FLAG, 32'h0);
    wr(`TSEG_OFF_CMD, 32'h0);
    rd_chk(`TSEG_OFF_FLAG, 32'h0);
  endtask : t_trigger

  task automatic t_chan();
    int s;
    wr(`TSEG_OFF_CHMODE, 32'hf);
    wr(`TSEG_OFF_INTEN, 32'h1e1e);
    wr(`TSEG_OFF_CNT, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      s = ch_seen;
      wr(`TSEG_OFF_CMD, 32'h2 << i);
      waitn(2);
      chk({28'h0, ch_irq}, (32'h2 << i) - 1, "channel irq");
      waitn(2);
      chk(ch_seen - s, 32'h1, "channel dma");
    end
    rd_chk(`TSEG_OFF_FLAG, 32'h1e);
    for (int i = 0; i < 4; i++) begin
      rd_chk(`TSEG_OFF_CV0 + `TSEG_CV_STEP * i, 32'h1234);
    end
    rd_chk(`TSEG_OFF_FLAG, 32'h0);
    // Second capture while flag still set
    wr(`TSEG_OFF_CMD, 32'h2);
    wr(`TSEG_OFF_CMD, 32'h2);
    rd_chk(`TSEG_OFF_FLAG, 32'h202);
    wr(`TSEG_OFF_FLAG, 32'h0);
    // Output mode: value is writable and a forced event does not capture
    wr(`TSEG_OFF_CHMODE, 32'h0);
    wr(`TSEG_OFF_CV0, 32'habcd);
    wr(`TSEG_OFF_CMD, 32'h2);
    rd_chk(`TSEG_OFF_CV0, 32'habcd);
    rd_chk(`TSEG_OFF_FLAG, 32'h2);
    wr(`TSEG_OFF_FLAG, 32'h0);
  endtask : t_chan

  task automatic t_update();
    logic [31:0] m[5] = '{32'h00, 32'h10, 32'h20, 32'h40, 32'h60};
    logic [31:0] e[5] = '{32'h0, 32'h77, 32'h0, 32'h0, 32'h0};
    int s;
    wr(`TSEG_OFF_INTEN, 32'h0101);
    wr(`TSEG_OFF_ARR, 32'h77);
    for (int i = 0; i < 5; i++) begin
      wr(`TSEG_OFF_CTRL, m[i]);
      wr(`TSEG_OFF_CNT, 32'h55);
      s = up_seen;
      wr(`TSEG_OFF_CMD, 32'h1);
      rd_chk(`TSEG_OFF_CNT, e[i]);
      chk({31'h0, up_irq}, 32'h1, "update irq");
      chk(up_seen - s, 32'h1, "update dma");
      rd_chk(`TSEG_OFF_FLAG, 32'h1);
      wr(`TSEG_OFF_FLAG, 32'h0);
    end
  endtask : t_update

  // Step lands 16 cycles after the forced update only if prescaler restarts
  task automatic t_presc();
    wr(`TSEG_OFF_ARR, 32'hffff);
    wr(`TSEG_OFF_PSC, 32'hf);
    wr(`TSEG_OFF_CTRL, 32'h1);
    waitn(21);
    wr(`TSEG_OFF_CMD, 32'h1);
    waitn(12);
    rd_chk(`TSEG_OFF_CNT, 32'h0);
    wr(`TSEG_OFF_CTRL, 32'h0);
  endtask : t_presc

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_trigger();
    t_chan();
    t_update();
    t_presc();
    conclude();
  end
endmodule : timer_soft_event_gen_test
